// file: rtl/fcs_pkg.sv
// package: register map, field positions, reset values and bus codes of the flash command status block
package fcs_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] FCS_ADDR_STATUS = 8'h00;
   localparam logic [7:0] FCS_ADDR_CONFIG = 8'h04;
   localparam logic [7:0] FCS_ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] FCS_ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] FCS_ADDR_CMD_OBJECT = 8'h10;

   // ---------------------------------------------------------------
   // flash_status fields
   // ---------------------------------------------------------------
   localparam int FCS_CMD_DONE_BIT = 7;
   localparam int FCS_READ_COLL_BIT = 6;
   localparam int FCS_ACCESS_ERR_BIT = 5;
   localparam int FCS_PROT_VIOL_BIT = 4;
   localparam int FCS_CMD_ERR_BIT = 0;
   localparam logic [7:0] FCS_STATUS_RESET = 8'h00;

   // ---------------------------------------------------------------
   // flash_config fields
   // ---------------------------------------------------------------
   localparam int FCS_CMD_DONE_IE_BIT = 7;
   localparam int FCS_READ_COLL_IE_BIT = 6;
   localparam logic [7:0] FCS_CONFIG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // event status / mask fields
   // ---------------------------------------------------------------
   localparam int FCS_EV_CMD_DONE = 0;
   localparam int FCS_EV_READ_COLL = 1;
   localparam int FCS_EV_ACCESS_ERR = 2;
   localparam int FCS_EV_PROT_VIOL = 3;
   localparam int FCS_EV_W = 4;
   localparam logic [3:0] FCS_EV_RESET = 4'h0;
   localparam logic [31:0] FCS_CMD_OBJECT_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // bus response codes
   // ---------------------------------------------------------------
   localparam logic [1:0] FCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] FCS_RESP_SLVERR = 2'h2;

endpackage

// file: rtl/fcs_flash_command_status.sv
// module: flash command status register block with AXI4-Lite slave and interrupt logic
`timescale 1ns/10ps
module fcs_flash_command_status
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // command engine side
   input wire logic init_done,
   input wire logic init_error,
   input wire logic cmd_finish,
   input wire logic cmd_error,
   input wire logic access_violation,
   input wire logic protect_violation,
   input wire logic flash_read,
   input wire logic read_resource_busy,
   output logic cmd_launch,
   output logic [31:0] cmd_object,
   output logic read_data_unreliable,
   // interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic awready;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic init_seen;
      logic cmd_done;
      logic read_coll;
      logic access_err;
      logic prot_viol;
      logic cmd_err;
      logic cmd_done_ie;
      logic read_coll_ie;
      logic [3:0] ev_status;
      logic [3:0] ev_mask;
      logic [31:0] cmd_obj;
      logic launch;
      logic unreliable;
      logic irq;
   } fcs_state_t;

   fcs_state_t state_q;
   fcs_state_t state_d;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // sticky flag: a set in the same cycle as a clear wins
   function automatic logic fcs_sticky(input logic old, input logic set, input logic clr);
      fcs_sticky = set | (old & ~clr);
   endfunction

   function automatic logic [31:0] fcs_status_word(input fcs_state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[fcs_pkg::FCS_CMD_DONE_BIT] = s.cmd_done;
      v[fcs_pkg::FCS_READ_COLL_BIT] = s.read_coll;
      v[fcs_pkg::FCS_ACCESS_ERR_BIT] = s.access_err;
      v[fcs_pkg::FCS_PROT_VIOL_BIT] = s.prot_viol;
      v[fcs_pkg::FCS_CMD_ERR_BIT] = s.cmd_err;
      fcs_status_word = v;
   endfunction

   // write to an 8-bit register, which needs byte lane 0
   function automatic logic fcs_lane0_wr(input logic wr, input logic [7:0] a, input logic [7:0] target,
                                         input logic [3:0] strb);
      logic hit;
      hit = wr && (a == target);
      fcs_lane0_wr = hit && strb[0];
   endfunction

   // address decode shared by the write and read channels
   function automatic logic fcs_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         fcs_pkg::FCS_ADDR_STATUS: hit = 1'b1;
         fcs_pkg::FCS_ADDR_CONFIG: hit = 1'b1;
         fcs_pkg::FCS_ADDR_IRQ_STATUS: hit = 1'b1;
         fcs_pkg::FCS_ADDR_IRQ_MASK: hit = 1'b1;
         fcs_pkg::FCS_ADDR_CMD_OBJECT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      fcs_mapped = hit;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic do_write;
   logic st_wr;
   logic cfg_wr;
   logic busy;
   logic launch_ok;
   logic coll_ev;
   logic done_ev;
   logic abort_ev;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic mapped_w;
   logic mapped_r;
   logic wr_lock;

   always_comb
   begin
      state_d = state_q;
      state_d.launch = 1'b0;
      state_d.unreliable = 1'b0;

      // write channel capture, either order
      if (s_axi_awvalid && state_q.awready)
      begin
         state_d.aw_have = 1'b1;
         state_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_q.wready)
      begin
         state_d.w_have = 1'b1;
         state_d.w_data = s_axi_wdata;
         state_d.w_strb = s_axi_wstrb;
      end
      if (state_q.bvalid && s_axi_bready)
      begin
         state_d.bvalid = 1'b0;
      end

      do_write = state_q.aw_have && state_q.w_have && !state_q.bvalid;
      busy = !state_q.cmd_done;
      // only status and configuration stay writable while a command runs after initialisation
      wr_lock = busy && state_q.init_seen;
      st_wr = fcs_lane0_wr(do_write, state_q.aw_addr, fcs_pkg::FCS_ADDR_STATUS, state_q.w_strb);
      cfg_wr = fcs_lane0_wr(do_write, state_q.aw_addr, fcs_pkg::FCS_ADDR_CONFIG, state_q.w_strb);
      mapped_w = fcs_mapped(state_q.aw_addr);

      // launch needs idle controller and no pending access or protection error flag
      launch_ok = st_wr && state_q.w_data[fcs_pkg::FCS_CMD_DONE_BIT] && state_q.cmd_done &&
                  !state_q.access_err && !state_q.prot_viol;

      if (init_done)
      begin
         state_d.init_seen = 1'b1;
      end

      // completion flag
      abort_ev = busy && state_q.init_seen && (access_violation || protect_violation);
      done_ev = (busy && ((state_q.init_seen && cmd_finish) || (!state_q.init_seen && init_done))) ||
                abort_ev;
      if (launch_ok)
      begin
         state_d.cmd_done = 1'b0;
         state_d.launch = 1'b1;
         state_d.cmd_err = 1'b0;
      end
      else if (done_ev)
      begin
         state_d.cmd_done = 1'b1;
      end

      // read-only completion error status
      if (busy && !state_q.init_seen && init_done && init_error)
      begin
         state_d.cmd_err = 1'b1;
      end
      if (busy && state_q.init_seen && cmd_finish && cmd_error && !launch_ok)
      begin
         state_d.cmd_err = 1'b1;
      end

      // error flags, write one to clear, write zero no effect
      coll_ev = flash_read && read_resource_busy && busy;
      state_d.unreliable = coll_ev;
      state_d.read_coll = fcs_sticky(state_q.read_coll, coll_ev,
                                     st_wr && state_q.w_data[fcs_pkg::FCS_READ_COLL_BIT]);
      state_d.access_err = fcs_sticky(state_q.access_err, access_violation,
                                      st_wr && state_q.w_data[fcs_pkg::FCS_ACCESS_ERR_BIT]);
      state_d.prot_viol = fcs_sticky(state_q.prot_viol, protect_violation,
                                     st_wr && state_q.w_data[fcs_pkg::FCS_PROT_VIOL_BIT]);

      // configuration, always writable
      if (cfg_wr)
      begin
         state_d.cmd_done_ie = state_q.w_data[fcs_pkg::FCS_CMD_DONE_IE_BIT];
         state_d.read_coll_ie = state_q.w_data[fcs_pkg::FCS_READ_COLL_IE_BIT];
      end

      // command object: frozen while a command runs after initialisation
      if (do_write && (state_q.aw_addr == fcs_pkg::FCS_ADDR_CMD_OBJECT) && !wr_lock)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (state_q.w_strb[i])
            begin
               state_d.cmd_obj[i*8 +: 8] = state_q.w_data[i*8 +: 8];
            end
         end
      end

      // event status and mask
      ev_set = 4'h0;
      ev_set[fcs_pkg::FCS_EV_CMD_DONE] = done_ev && !launch_ok;
      ev_set[fcs_pkg::FCS_EV_READ_COLL] = coll_ev;
      ev_set[fcs_pkg::FCS_EV_ACCESS_ERR] = access_violation;
      ev_set[fcs_pkg::FCS_EV_PROT_VIOL] = protect_violation;
      ev_clr = 4'h0;
      // event registers are locked like the command object
      if (fcs_lane0_wr(do_write, state_q.aw_addr, fcs_pkg::FCS_ADDR_IRQ_STATUS, state_q.w_strb) && !wr_lock)
      begin
         ev_clr = state_q.w_data[3:0];
      end
      for (int i = 0; i < fcs_pkg::FCS_EV_W; i++)
      begin
         state_d.ev_status[i] = fcs_sticky(state_q.ev_status[i], ev_set[i], ev_clr[i]);
      end
      if (fcs_lane0_wr(do_write, state_q.aw_addr, fcs_pkg::FCS_ADDR_IRQ_MASK, state_q.w_strb) && !wr_lock)
      begin
         state_d.ev_mask = state_q.w_data[3:0];
      end

      // write response
      if (do_write)
      begin
         state_d.aw_have = 1'b0;
         state_d.w_have = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp = mapped_w ? fcs_pkg::FCS_RESP_OKAY : fcs_pkg::FCS_RESP_SLVERR;
      end
      state_d.awready = !state_d.aw_have && !state_d.bvalid;
      state_d.wready = !state_d.w_have && !state_d.bvalid;

      // read channel
      if (state_q.rvalid && s_axi_rready)
      begin
         state_d.rvalid = 1'b0;
      end
      // unmapped reads answer zero with an error response
      mapped_r = fcs_mapped(s_axi_araddr);
      if (s_axi_arvalid && state_q.arready)
      begin
         state_d.rvalid = 1'b1;
         case (s_axi_araddr)
            fcs_pkg::FCS_ADDR_STATUS: state_d.rdata = fcs_status_word(state_q);
            fcs_pkg::FCS_ADDR_CONFIG:
            begin
               state_d.rdata = 32'h0000_0000;
               state_d.rdata[fcs_pkg::FCS_CMD_DONE_IE_BIT] = state_q.cmd_done_ie;
               state_d.rdata[fcs_pkg::FCS_READ_COLL_IE_BIT] = state_q.read_coll_ie;
            end
            fcs_pkg::FCS_ADDR_IRQ_STATUS: state_d.rdata = {28'h0000000, state_q.ev_status};
            fcs_pkg::FCS_ADDR_IRQ_MASK: state_d.rdata = {28'h0000000, state_q.ev_mask};
            fcs_pkg::FCS_ADDR_CMD_OBJECT: state_d.rdata = state_q.cmd_obj;
            default:
            begin
               state_d.rdata = 32'h0000_0000;
            end
         endcase
         state_d.rresp = mapped_r ? fcs_pkg::FCS_RESP_OKAY : fcs_pkg::FCS_RESP_SLVERR;
      end
      state_d.arready = !state_d.rvalid;

      // interrupt from next-state values
      state_d.irq = (state_d.cmd_done && state_d.cmd_done_ie) ||
                    (state_d.read_coll && state_d.read_coll_ie) ||
                    (|(state_d.ev_status & state_d.ev_mask));
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_q <= '0;
         state_q.awready <= 1'b0;
         state_q.cmd_done <= fcs_pkg::FCS_STATUS_RESET[fcs_pkg::FCS_CMD_DONE_BIT];
         state_q.cmd_done_ie <= fcs_pkg::FCS_CONFIG_RESET[fcs_pkg::FCS_CMD_DONE_IE_BIT];
         state_q.read_coll_ie <= fcs_pkg::FCS_CONFIG_RESET[fcs_pkg::FCS_READ_COLL_IE_BIT];
         state_q.ev_status <= fcs_pkg::FCS_EV_RESET;
         state_q.ev_mask <= fcs_pkg::FCS_EV_RESET;
         state_q.cmd_obj <= fcs_pkg::FCS_CMD_OBJECT_RESET;
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = state_q.awready;
   assign s_axi_wready = state_q.wready;
   assign s_axi_bvalid = state_q.bvalid;
   assign s_axi_bresp = state_q.bresp;
   assign s_axi_arready = state_q.arready;
   assign s_axi_rvalid = state_q.rvalid;
   assign s_axi_rdata = state_q.rdata;
   assign s_axi_rresp = state_q.rresp;
   assign cmd_launch = state_q.launch;
   assign cmd_object = state_q.cmd_obj;
   assign read_data_unreliable = state_q.unreliable;
   assign irq = state_q.irq;

endmodule

// file: sim/fcs_status_properties.sv
// checker: port-level properties of the flash command status block
`timescale 1ns/10ps
module fcs_status_properties
(
   // clock, reset and enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   // command engine
   input wire logic cmd_finish,
   input wire logic access_violation,
   input wire logic protect_violation,
   input wire logic flash_read,
   input wire logic read_resource_busy,
   input wire logic cmd_launch,
   input wire logic [31:0] cmd_object,
   input wire logic read_data_unreliable
);
   logic busy_q;
   logic [7:0] ar_q;

   // ---------------------------------------------------------------
   // command-in-progress tracker and read address capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         busy_q <= 1'b0;
         ar_q <= 8'h00;
      end
      else if (ce)
      begin
         if (cmd_launch)
            busy_q <= 1'b1;
         else if (cmd_finish || access_violation || protect_violation)
            busy_q <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
            ar_q <= s_axi_araddr;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_launch_pulse: assert property (cmd_launch |=> !cmd_launch)
      else $error("launch pulse longer than one cycle");
   a_launch_at_resp: assert property (cmd_launch |-> $rose(s_axi_bvalid))
      else $error("launch not aligned with write response");
   a_no_relaunch: assert property (busy_q |-> !cmd_launch)
      else $error("launch while a command runs");
   a_coll_flagged: assert property (ce && flash_read && read_resource_busy && busy_q |=> read_data_unreliable)
      else $error("collision read not flagged");
   a_coll_cause: assert property ($rose(read_data_unreliable) |-> $past(flash_read && read_resource_busy))
      else $error("unreliable data without a colliding read");
   a_spare_bits_zero: assert property (s_axi_rvalid && ar_q == 8'h00 |->
      {s_axi_rdata[31:8], s_axi_rdata[3:1]} == 27'h0) else $error("unassigned status bits not zero");
   a_busy_reads_low: assert property ($rose(s_axi_rvalid) && ar_q == 8'h00 && $past(busy_q) |-> !s_axi_rdata[7])
      else $error("completion flag high while busy");
   a_object_frozen: assert property (busy_q |=> $stable(cmd_object))
      else $error("command object changed while busy");
endmodule

bind fcs_flash_command_status fcs_status_properties u_fcs_status_properties
(
   .clk, .rstn, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid,
   .cmd_finish, .access_violation, .protect_violation, .flash_read, .read_resource_busy, .cmd_launch,
   .cmd_object, .read_data_unreliable
);

// file: sim/tb.sv
// testbench: register and engine-port tests of the flash command status block
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic ierr = 1'b0, cerr = 1'b0, rbusy = 1'b0;
   logic [4:0] eng = 5'h00;
   logic awr, wrdy, bv, arr, rv, launch, unrel_o, irq, launch_seen, unrel;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic ce = 1'b1;
   logic [31:0] cobj;
   int miscompares = 0;
   int cmp_count = 0;

   fcs_flash_command_status u_fcs_flash_command_status
   (
      .clk(clk), .rstn(rstn), .ce(ce),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .init_done(eng[4]), .init_error(ierr), .cmd_finish(eng[3]), .cmd_error(cerr),
      .access_violation(eng[2]), .protect_violation(eng[1]), .flash_read(eng[0]), .read_resource_busy(rbusy),
      .cmd_launch(launch), .cmd_object(cobj), .read_data_unreliable(unrel_o), .irq(irq)
   );

   // ---------------------------------------------------------------
   // clock, checks and bus tasks
   // ---------------------------------------------------------------
   initial forever #12.5 clk = ~clk;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = fcs_pkg::FCS_RESP_OKAY);
      int n = 0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (awr)
            awv <= 1'b0;
         if (wrdy)
            wv <= 1'b0;
      end while (!bv && n < 40);
      chk("bvalid", 32'h1, bv);
      chk("bresp", er, bresp);
      launch_seen = launch;
      bry <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = fcs_pkg::FCS_RESP_OKAY);
      int n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (arr)
            arv <= 1'b0;
      end while (!rv && n < 40);
      chk("rvalid", 32'h1, rv);
      chk("rdata", e, rdata);
      chk("rresp", er, rresp);
      rry <= 1'b0;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      eng[i] <= 1'b1;
      @(posedge clk);
      eng <= 5'h00;
      @(posedge clk);
      unrel = unrel_o;
   endtask

   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk);
      chk("irq", e, irq);
   endtask

   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      #100000;
      miscompares++;
      wrap_up();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h40, 32'h0, fcs_pkg::FCS_RESP_SLVERR);
      wr(8'h40, 32'h1, fcs_pkg::FCS_RESP_SLVERR);
      ierr <= 1'b1;
      pulse(4);
      ierr <= 1'b0;
      rd(8'h00, 32'h81);
      wr(8'h00, 32'h0f);
      chk("launch", 1'b0, launch_seen);
      rd(8'h00, 32'h81);
      wr(8'h04, 32'h80);
      chk_irq(1'b1);
      wr(8'h04, 32'h0);
      chk_irq(1'b0);
      wr(8'h00, 32'h80);
      chk("launch", 1'b1, launch_seen);
      rd(8'h00, 32'h0);
      wr(8'h10, 32'h1234_5678);
      rd(8'h10, 32'h0);
      chk("cmd_object", 32'h0, cobj);
      wr(8'h00, 32'h80);
      chk("launch", 1'b0, launch_seen);
      rbusy <= 1'b1;
      pulse(0);
      rbusy <= 1'b0;
      chk("unreliable", 1'b1, unrel);
      rd(8'h00, 32'h40);
      wr(8'h04, 32'h40);
      chk_irq(1'b1);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h40);
      wr(8'h00, 32'h40);
      rd(8'h00, 32'h0);
      chk_irq(1'b0);
      cerr <= 1'b1;
      pulse(3);
      cerr <= 1'b0;
      rd(8'h00, 32'h81);
      rd(8'h08, 32'h3);
      wr(8'h0c, 32'h1);
      chk_irq(1'b1);
      wr(8'h08, 32'h1);
      chk_irq(1'b0);
      wr(8'h0c, 32'h0);
      rd(8'h08, 32'h2);
      for (int i = 0; i < 2; i++)
      begin
         wr(8'h00, 32'h80);
         chk("launch", 1'b1, launch_seen);
         rd(8'h00, 32'h0);
         wr(8'h0c, 32'hf);
         rd(8'h0c, 32'h0);
         pulse(2 - i);
         rd(8'h00, 32'h80 | (32'h20 >> i));
         wr(8'h00, 32'h80);
         chk("launch", 1'b0, launch_seen);
         wr(8'h00, 32'h0);
         rd(8'h00, 32'h80 | (32'h20 >> i));
         wr(8'h00, 32'h20 >> i);
         rd(8'h00, 32'h80);
      end
      wr(8'h10, 32'hcafe_0001);
      rd(8'h10, 32'hcafe_0001);
      chk("cmd_object", 32'hcafe_0001, cobj);
      ce <= 1'b0;
      pulse(2);
      ce <= 1'b1;
      rd(8'h00, 32'h80);
      wrap_up();
   end
endmodule
